// ===== tmr_irq.sv
// module: interrupt enable, status flags and capture registers of a two-channel timer
//
// Contract
// - trigger interrupt enable at bit 6 gates the trigger flag request.
// - channel interrupt enables at bits 1 and 2 gate channel flags.
// - update interrupt enable at bit 0 gates the update flag.
// - overcapture flags (bits 9, 10) set only in input capture mode.
// - capture while channel flag still set raises its overcapture flag.
// - overcapture flag clears only by software writing zero.
// - trigger flag sets on rising trigger edge, and on both rising and falling edges in gated mode.
// - output channel flag sets on compare match, not in center-aligned mode.
// - compare above reload sets flag on overflow (up or center-aligned) or underflow (down, edge-aligned).
// - input channel flag sets on each capture event.
// - update flag sets on overflow or underflow when updates are enabled.
// - software update request sets update flag if source and disable are zero.
// - reset-mode trigger reinit sets update flag if source and disable are zero.
// - trigger, output channel and update flags stay set until software clears.
// - gated mode runs the counter while trigger is high, halts when low.
// - software trigger request sets the trigger flag and self-clears.
module tmr_irq
   import tmr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire tmr_core_t CORE,
   input wire logic SLAVE_TRIGGER_IN,
   output logic TIMER_IRQ,
   output logic COUNTER_RUN_EN,
   output logic UPDATE_REQ_PULSE
);

   tmr_state_t s_q;
   tmr_state_t s_d;
   logic trig_level;
   logic trig_rise;
   logic trig_fall;

   // ------------------------------------------------------------
   // trigger input conditioning
   // ------------------------------------------------------------
   tmr_trig_edge u_trig (
      .clk(CLK),
      .reset_n(RESET_N),
      .din(SLAVE_TRIGGER_IN),
      .level(trig_level),
      .rise(trig_rise),
      .fall(trig_fall)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic acc;
      logic wr;
      logic rd;
      logic hit;
      logic [31:0] rdata;
      logic [2:0] sms;
      logic [1:0] cams;
      logic center;
      logic update_disable;
      logic update_request_source;
      logic sw_trig;
      logic sw_upd;
      logic reinit;
      logic [15:0] set_v;
      logic [15:0] clr_v;
      logic [15:0] ccv;
      logic ch_in;
      logic cap;
      logic match;
      logic beyond;
      logic rd_ccv;
      logic wr_ccv;

      s_d = s_q;
      acc = PSEL & PENABLE & s_q.pready;
      wr = acc & PWRITE;
      rd = acc & ~PWRITE;
      hit = 1'b0;
      rdata = TMR_RST32;
      sms = s_q.cfg[2:0];
      cams = s_q.ctrl[TMR_B_CAMS +: 2];
      center = (cams != TMR_CAMS_EDGE);
      update_disable = s_q.ctrl[TMR_B_UPDATE_DISABLE];
      update_request_source = s_q.ctrl[TMR_B_UPDATE_REQUEST_SOURCE];
      set_v = TMR_RST16;
      clr_v = TMR_RST16;
      ccv = TMR_RST16;
      ch_in = 1'b0;
      cap = 1'b0;
      match = 1'b0;
      beyond = 1'b0;
      rd_ccv = 1'b0;
      wr_ccv = 1'b0;
      sw_trig = 1'b0;
      sw_upd = 1'b0;
      reinit = 1'b0;

      // ------------------------------------------------------------
      // apb: one wait state so every answer leaves a flop
      // ------------------------------------------------------------
      s_d.pready = PSEL & PENABLE & ~s_q.pready;
      case (PADDR)
         TMR_OFS_CTRL: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.ctrl};
         end
         TMR_OFS_CFG: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.cfg};
         end
         TMR_OFS_IEN: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.ien};
         end
         TMR_OFS_STS: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.sts};
         end
         TMR_OFS_EVG: begin
            // request bits are self-clearing and always read zero
            hit = 1'b1;
         end
         TMR_OFS_CCV1: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.ccv1};
         end
         TMR_OFS_CCV2: begin
            hit = 1'b1;
            rdata = {16'h0000, s_q.ccv2};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (PSEL & PENABLE & ~s_q.pready) begin
         s_d.prdata = PWRITE ? TMR_RST32 : rdata;
         s_d.pslverr = ~hit;
      end else begin
         s_d.prdata = TMR_RST32;
         s_d.pslverr = 1'b0;
      end

      // ------------------------------------------------------------
      // plain register writes
      // ------------------------------------------------------------
      if (wr && PADDR == TMR_OFS_CTRL) begin
         s_d.ctrl = PWDATA[15:0] & TMR_CTRL_MASK;
      end
      if (wr && PADDR == TMR_OFS_CFG) begin
         s_d.cfg = PWDATA[15:0] & TMR_CFG_MASK;
      end
      if (wr && PADDR == TMR_OFS_IEN) begin
         s_d.ien = PWDATA[15:0] & TMR_IEN_MASK;
      end

      // ------------------------------------------------------------
      // trigger and update events
      // ------------------------------------------------------------
      // request bits never stored, so they clear by themselves
      sw_trig = wr && PADDR == TMR_OFS_EVG && PWDATA[TMR_B_TRIG];
      sw_upd = wr && PADDR == TMR_OFS_EVG && PWDATA[TMR_B_UPD];
      reinit = (sms == TMR_SMS_RESET) & trig_rise;
      if (sms == TMR_SMS_GATED) begin
         set_v[TMR_B_TRIG] = trig_rise | trig_fall | sw_trig;
      end else begin
         set_v[TMR_B_TRIG] = trig_rise | sw_trig;
      end
      set_v[TMR_B_UPD] = ((CORE.overflow | CORE.underflow) & ~update_disable)
         | (sw_upd & ~update_request_source & ~update_disable)
         | (reinit & ~update_request_source & ~update_disable);
      s_d.upd_pulse = sw_upd | reinit;
      // gated mode halts without reset; the core keeps its count
      s_d.run_en = (sms == TMR_SMS_GATED) ? trig_level : 1'b1;

      // ------------------------------------------------------------
      // per-channel compare, capture and overcapture
      // ------------------------------------------------------------
      for (int i = 0; i < TMR_NCH; i++) begin
         ccv = (i == 0) ? s_q.ccv1 : s_q.ccv2;
         ch_in = s_q.cfg[TMR_B_CHIN + i];
         cap = CORE.capture[i] & ch_in;
         rd_ccv = rd && PADDR == ((i == 0) ? TMR_OFS_CCV1 : TMR_OFS_CCV2);
         wr_ccv = wr && PADDR == ((i == 0) ? TMR_OFS_CCV1 : TMR_OFS_CCV2);
         match = ~ch_in & ~center & (CORE.counter_value == ccv);
         beyond = ~ch_in & (ccv > CORE.auto_reload_value)
            & ((CORE.overflow & (~CORE.count_down | center))
            | (CORE.underflow & CORE.count_down & ~center));
         set_v[TMR_B_CH1 + i] = ch_in ? cap : (match | beyond);
         // old flag still up when a new value lands: data was lost
         set_v[TMR_B_OVC1 + i] = cap & s_q.sts[TMR_B_CH1 + i];
         clr_v[TMR_B_CH1 + i] = rd_ccv & ch_in;
         if (cap) begin
            ccv = CORE.counter_value;
         end else if (wr_ccv && !ch_in) begin
            ccv = PWDATA[15:0];
         end
         if (i == 0) begin
            s_d.ccv1 = ccv;
         end else begin
            s_d.ccv2 = ccv;
         end
      end

      // ------------------------------------------------------------
      // status flags: write zero clears, write one keeps, set wins
      // ------------------------------------------------------------
      if (wr && PADDR == TMR_OFS_STS) begin
         clr_v = clr_v | ~PWDATA[15:0];
      end
      s_d.sts = ((s_q.sts & ~clr_v) | set_v) & TMR_STS_MASK;

      // overcapture bits sit outside the enable mask, so add no request
      s_d.irq = |(s_d.sts & s_d.ien & TMR_IEN_MASK);
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign TIMER_IRQ = s_q.irq;
   assign COUNTER_RUN_EN = s_q.run_en;
   assign UPDATE_REQ_PULSE = s_q.upd_pulse;

endmodule // tmr_irq

// ===== tmr_pkg.sv
// package: register map, field positions, mode codes and state types of the timer irq block
package tmr_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] TMR_OFS_CTRL = 8'h00;
   localparam logic [7:0] TMR_OFS_CFG = 8'h08;
   localparam logic [7:0] TMR_OFS_IEN = 8'h0c;
   localparam logic [7:0] TMR_OFS_STS = 8'h10;
   localparam logic [7:0] TMR_OFS_EVG = 8'h14;
   localparam logic [7:0] TMR_OFS_CCV1 = 8'h34;
   localparam logic [7:0] TMR_OFS_CCV2 = 8'h38;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned TMR_B_UPD = 0;
   localparam int unsigned TMR_B_CH1 = 1;
   localparam int unsigned TMR_B_TRIG = 6;
   localparam int unsigned TMR_B_OVC1 = 9;
   localparam int unsigned TMR_B_UPDATE_DISABLE = 1;
   localparam int unsigned TMR_B_UPDATE_REQUEST_SOURCE = 2;
   localparam int unsigned TMR_B_CAMS = 5;
   localparam int unsigned TMR_B_CHIN = 8;
   localparam int unsigned TMR_NCH = 2;

   // ------------------------------------------------------------
   // masks, reset values, mode codes
   // ------------------------------------------------------------
   localparam logic [15:0] TMR_IEN_MASK = 16'h0047;
   localparam logic [15:0] TMR_STS_MASK = 16'h0647;
   localparam logic [15:0] TMR_CTRL_MASK = 16'h0066;
   localparam logic [15:0] TMR_CFG_MASK = 16'h0307;
   localparam logic [15:0] TMR_RST16 = 16'h0000;
   localparam logic [31:0] TMR_RST32 = 32'h0000_0000;
   localparam logic [2:0] TMR_SMS_RESET = 3'h4;
   localparam logic [2:0] TMR_SMS_GATED = 3'h5;
   localparam logic [1:0] TMR_CAMS_EDGE = 2'h0;

   // ------------------------------------------------------------
   // carriers and state
   // ------------------------------------------------------------
   typedef struct packed {
      logic overflow;
      logic underflow;
      logic count_down;
      logic [1:0] capture;
      logic [15:0] counter_value;
      logic [15:0] auto_reload_value;
   } tmr_core_t;

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic rise;
      logic fall;
   } tmr_edge_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] cfg;
      logic [15:0] ien;
      logic [15:0] sts;
      logic [15:0] ccv1;
      logic [15:0] ccv2;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic run_en;
      logic upd_pulse;
   } tmr_state_t;

endpackage

// ===== tmr_trig_edge.sv
// module: two-flop synchroniser and edge detector for the slave trigger input
module tmr_trig_edge
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);

   tmr_edge_t e_q;
   tmr_edge_t e_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      e_d = e_q;
      e_d.meta = din;
      e_d.sync = e_q.meta;
      e_d.prev = e_q.sync;
      // edges registered so the main block sees clean one-cycle pulses
      e_d.rise = e_q.sync & ~e_q.prev;
      e_d.fall = ~e_q.sync & e_q.prev;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         e_q <= '0;
      end else begin
         e_q <= e_d;
      end
   end

   assign level = e_q.prev;
   assign rise = e_q.rise;
   assign fall = e_q.fall;

endmodule // tmr_trig_edge

// ===== tmr_irq_asserts.sv
// checker: port-level assertions of the timer irq block
module tmr_irq_asserts
   import tmr_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire tmr_core_t CORE,
   input wire logic SLAVE_TRIGGER_IN,
   input wire logic TIMER_IRQ,
   input wire logic COUNTER_RUN_EN,
   input wire logic UPDATE_REQ_PULSE
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // register shadows and properties
   // ------------------------------------------------------------
   logic acc, wr, gated;
   logic [15:0] ien_q, ctrl_q, cfg_q;
   assign acc = PSEL && PENABLE && PREADY;
   assign wr = acc && PWRITE && !PSLVERR;
   assign gated = cfg_q[2:0] == TMR_SMS_GATED;
   // shadows commit on the same edge as the block, so no skew
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ien_q <= TMR_RST16;
         ctrl_q <= TMR_RST16;
         cfg_q <= TMR_RST16;
      end else if (wr) begin
         if (PADDR == TMR_OFS_IEN) ien_q <= PWDATA[15:0];
         if (PADDR == TMR_OFS_CTRL) ctrl_q <= PWDATA[15:0];
         if (PADDR == TMR_OFS_CFG) cfg_q <= PWDATA[15:0];
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_evg(int b); wr && PADDR == TMR_OFS_EVG && PWDATA[b]; endsequence
   sequence s_low(); (gated && !SLAVE_TRIGGER_IN) [*5]; endsequence
   property p_trg_sw; ien_q[6] ##0 s_evg(TMR_B_TRIG) |-> ##[1:2] TIMER_IRQ; endproperty
   property p_upd_sw; ien_q[0] && ctrl_q[2:1] == 2'h0 ##0 s_evg(TMR_B_UPD) |-> ##[1:2] TIMER_IRQ; endproperty
   property p_ovf; CORE.overflow && ien_q[0] && !ctrl_q[TMR_B_UPDATE_DISABLE] |=> TIMER_IRQ; endproperty
   property p_cap; CORE.capture[0] && cfg_q[TMR_B_CHIN] && ien_q[1] |=> TIMER_IRQ; endproperty
   property p_pin; !gated && ien_q[6] && $rose(SLAVE_TRIGGER_IN) |-> ##[2:5] TIMER_IRQ; endproperty
   property p_run_off; s_low() |-> !COUNTER_RUN_EN; endproperty
   property p_run_on; (!gated) [*3] |-> COUNTER_RUN_EN; endproperty
   property p_sticky; $fell(TIMER_IRQ) |-> $past(acc) || $past(acc, 2) || !$past(RESET_N); endproperty
   property p_upd_pulse; s_evg(TMR_B_UPD) |=> UPDATE_REQ_PULSE; endproperty
   a_trg_sw: assert property (p_trg_sw) else $error("sw trig no irq");
   a_upd_sw: assert property (p_upd_sw) else $error("sw upd no irq");
   a_ovf: assert property (p_ovf) else $error("ovf no irq");
   a_cap: assert property (p_cap) else $error("cap no irq");
   a_pin: assert property (p_pin) else $error("pin edge no irq");
   a_run_off: assert property (p_run_off) else $error("run while low");
   a_run_on: assert property (p_run_on) else $error("not running");
   a_sticky: assert property (p_sticky) else $error("irq fell alone");
   a_upd_pulse: assert property (p_upd_pulse) else $error("sw upd no pulse");
endmodule // tmr_irq_asserts

// ===== tb_top.sv
// testbench: bus-level checks of the timer irq block
module tb_top
   import tmr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // stimulus, tasks and test sequence
   // ------------------------------------------------------------
   logic clk = 1'h0;
   logic rst_n, psel, pen, pwr, rdy, err, irq, run, trg, serr;
   logic [7:0] adr;
   logic [31:0] wd, rd;
   tmr_core_t core;
   int n_fail, cmp_count;
   always #10 clk = ~clk;
   tmr_irq u_dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(adr),
      .PWDATA(wd), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .CORE(core), .SLAVE_TRIGGER_IN(trg),
      .TIMER_IRQ(irq), .COUNTER_RUN_EN(run), .UPDATE_REQ_PULSE());
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   // reads compare against d; one idle cycle after each access
   task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm = "");
      int n;
      psel <= 1'h1;
      pwr <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'h1 && n < 9);
      if (rdy !== 1'h1) begin
         n_fail++;
         test_done();
      end
      if (!w) chk(nm, rd, d);
      serr = err;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   task automatic ev(input logic [2:0] b);
      core.overflow <= b[2];
      core.capture <= b[1:0];
      @(posedge clk);
      core.overflow <= 1'h0;
      core.capture <= 2'h0;
      @(posedge clk);
   endtask
   // six cycles covers the two-flop sync plus edge register
   task automatic trig(input logic v);
      trg <= v;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      {rst_n, psel, pen, pwr, trg, adr, wd} = '0;
      core = '{counter_value: 16'h00a5, auto_reload_value: 16'h00ff, default: '0};
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      ap(1'h0, TMR_OFS_STS, 32'h0, "sts");
      ap(1'h1, TMR_OFS_IEN, 32'h47);
      ap(1'h0, TMR_OFS_IEN, 32'h47, "ien");
      ap(1'h0, 8'h40, 32'h0, "hole");
      chk("slverr", serr, 32'h1);
      ap(1'h1, TMR_OFS_IEN, 32'h0);
      ev(3'h4);
      ap(1'h0, TMR_OFS_STS, 32'h1, "upd");
      chk("irq_off", irq, 32'h0);
      ap(1'h1, TMR_OFS_IEN, 32'h47);
      ap(1'h1, TMR_OFS_STS, 32'h0647);
      ap(1'h0, TMR_OFS_STS, 32'h1, "w1");
      chk("irq", irq, 32'h1);
      ap(1'h1, TMR_OFS_STS, 32'h0646);
      ap(1'h0, TMR_OFS_STS, 32'h0, "clr");
      chk("irq_clr", irq, 32'h0);
      ap(1'h1, TMR_OFS_CTRL, 32'h2);
      ev(3'h4);
      ap(1'h0, TMR_OFS_STS, 32'h0, "update_disable");
      for (int k = 0; k < 4; k++) begin
         ap(1'h1, TMR_OFS_CTRL, 32'(k * 2));
         ap(1'h1, TMR_OFS_EVG, 32'h1);
         ap(1'h0, TMR_OFS_STS, 32'(k == 0), "sw_upd");
         ap(1'h1, TMR_OFS_STS, 32'h0);
      end
      ap(1'h1, TMR_OFS_CTRL, 32'h0);
      ap(1'h1, TMR_OFS_EVG, 32'h40);
      ap(1'h0, TMR_OFS_STS, 32'h40, "sw_trg");
      chk("irq_trg", irq, 32'h1);
      ap(1'h1, TMR_OFS_STS, 32'h0);
      ap(1'h1, TMR_OFS_CFG, 32'h4);
      trig(1'h1);
      ap(1'h0, TMR_OFS_STS, 32'h41, "rise");
      ap(1'h1, TMR_OFS_STS, 32'h0);
      trig(1'h0);
      ap(1'h0, TMR_OFS_STS, 32'h0, "fall");
      ap(1'h1, TMR_OFS_CFG, 32'h5);
      trig(1'h1);
      chk("run_hi", run, 32'h1);
      ap(1'h0, TMR_OFS_STS, 32'h40, "g_rise");
      ap(1'h1, TMR_OFS_STS, 32'h0);
      trig(1'h0);
      chk("run_lo", run, 32'h0);
      ap(1'h0, TMR_OFS_STS, 32'h40, "g_fall");
      ap(1'h1, TMR_OFS_STS, 32'h0);
      ap(1'h1, TMR_OFS_CFG, 32'h100);
      ev(3'h2);
      ev(3'h2);
      ev(3'h1);
      ev(3'h1);
      ap(1'h0, TMR_OFS_STS, 32'h202, "ovc");
      ap(1'h0, TMR_OFS_CCV1, 32'ha5, "cap");
      ap(1'h0, TMR_OFS_STS, 32'h200, "rd_clr");
      ap(1'h1, TMR_OFS_STS, 32'h0447);
      ap(1'h0, TMR_OFS_STS, 32'h0, "ovc_clr");
      ap(1'h1, TMR_OFS_CCV1, 32'h1234);
      ap(1'h0, TMR_OFS_CCV1, 32'ha5, "cap_ro");
      ap(1'h1, TMR_OFS_CCV2, 32'ha5);
      ap(1'h0, TMR_OFS_STS, 32'h4, "cmp");
      ap(1'h1, TMR_OFS_CTRL, 32'h20);
      ap(1'h1, TMR_OFS_STS, 32'h0);
      ap(1'h0, TMR_OFS_STS, 32'h0, "center");
      ap(1'h1, TMR_OFS_CTRL, 32'h0);
      ap(1'h1, TMR_OFS_CCV2, 32'h1ff);
      ap(1'h1, TMR_OFS_STS, 32'h0);
      ev(3'h4);
      ap(1'h0, TMR_OFS_STS, 32'h5, "beyond");
      // down counting: reload overrun reported on underflow instead
      core.count_down <= 1'h1;
      ap(1'h1, TMR_OFS_STS, 32'h0);
      core.underflow <= 1'h1;
      @(posedge clk);
      core.underflow <= 1'h0;
      @(posedge clk);
      ap(1'h0, TMR_OFS_STS, 32'h5, "down");
      test_done();
   end
endmodule // tb_top
bind tmr_irq tmr_irq_asserts u_chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CORE(CORE), .SLAVE_TRIGGER_IN(SLAVE_TRIGGER_IN), .TIMER_IRQ(TIMER_IRQ), .COUNTER_RUN_EN(COUNTER_RUN_EN),
   .UPDATE_REQ_PULSE(UPDATE_REQ_PULSE));
